// ==== verilog/aoc_conditioner.sv ====
/*
  Airflow output conditioner for the primary measurement channel: field
  gain/offset correction, low-limit cutoff and percentage smoothing, with
  registers on AXI4-Lite and live gain entry through three buttons.
  Assumes samples arrive as a valid/ready stream on aclk, buttons are
  asynchronous pins, and the host takes results through out_valid/ready.

  // Operation
  // R1: correction is applied only to the primary airflow or pressure stream.
  // R2: with correction on, corrected value feeds display and output alike.
  // R3: with correction off, stored gain and offset are ignored entirely.
  // R4: correction is off after reset until software switches it on.
  // R5: entry mode 1 takes gain and offset as directly written values.
  // R6: entry mode 2 steps gain live by buttons; enter stores it.
  // R7: result forced to zero while the reading is below the cutoff.
  // R8: smoothing setting accepted from 0 (off) up to 99 percent.
  // R9: a larger smoothing percentage restricts change per update more.
  // R10: defaults are gain one, offset zero, direct entry, no smoothing.
  // R11: order is correction, cutoff, smoothing; result drives both outputs.
  // R12: each update moves (100 minus setting) percent toward the input.
*/
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module aoc_conditioner
  import aoc_pkg::*;
#(
  parameter int W = aoc_pkg::DATA_W
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [aoc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [aoc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      in_valid,
  output logic                           in_ready,
  input  wire logic [W-1:0]              in_value,
  output logic                           out_valid,
  input  wire logic                      out_ready,
  output logic [W-1:0]                   out_value,
  output logic [W-1:0]                   display_value,
  input  wire aoc_pkg::aoc_btn_t         btn
);
  import aoc_pkg::*;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a[1:0] == 2'b00) && (a <= REG_LIVE_GAIN);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  function automatic logic [W-1:0] mag(input logic [W-1:0] v);
    mag = v[W-1] ? W'(-v) : v;
  endfunction

  logic                        enable_ff;
  aoc_mode_t                   mode_ff;
  logic [GAIN_W-1:0]           gain_ff;
  logic [GAIN_W-1:0]           trial_gain_ff;
  logic [W-1:0]                offset_ff;
  logic [W-1:0]                cutoff_ff;
  logic [PCT_W-1:0]            smooth_ff;
  logic [W-1:0]                y_ff;
  aoc_btn_t                    btn_meta_ff;
  aoc_btn_t                    btn_sync_ff;
  aoc_btn_t                    btn_prev_ff;
  logic                        up_pulse;
  logic                        down_pulse;
  logic                        enter_pulse;
  logic                        aw_held_ff;
  logic                        w_held_ff;
  logic [ADDR_W-1:0]           awaddr_ff;
  logic [31:0]                 wdata_ff;
  logic [3:0]                  wstrb_ff;
  logic                        bvalid_ff;
  logic [1:0]                  bresp_ff;
  logic                        rvalid_ff;
  logic [31:0]                 rdata_ff;
  logic [1:0]                  rresp_ff;
  logic                        wr_do;
  logic [31:0]                 wr_val;
  logic [31:0]                 old_val;
  logic [31:0]                 nxt_rdata;
  logic [GAIN_W-1:0]           active_gain;
  logic signed [W+GAIN_W:0]    prod;
  logic signed [W+GAIN_W:0]    sum;
  logic [W-1:0]                corr_val;
  logic                        cut_hit;
  logic [W-1:0]                cut_val;
  logic signed [W:0]           diff;
  logic signed [W+9:0]         step_prod;
  logic signed [W:0]           step;
  logic [W:0]                  nxt_y_wide;
  logic [W-1:0]                nxt_y;
  logic                        fire;

  // two flops before the edge detector; meta stage read only by sync
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      btn_meta_ff <= '0;
      btn_sync_ff <= '0;
      btn_prev_ff <= '0;
    end else begin
      btn_meta_ff <= btn;
      btn_sync_ff <= btn_meta_ff;
      btn_prev_ff <= btn_sync_ff;
    end
  end

  assign up_pulse    = btn_sync_ff.up && !btn_prev_ff.up;
  assign down_pulse  = btn_sync_ff.down && !btn_prev_ff.down;
  assign enter_pulse = btn_sync_ff.enter && !btn_prev_ff.enter;

  // write channel: address and data taken in either order, one at a time
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign wr_do         = aw_held_ff && w_held_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awaddr_ff  <= '0;
      wdata_ff   <= 32'h00000000;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= is_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    old_val = 32'h00000000;
    case (awaddr_ff)
      REG_CONTROL:    old_val = {31'h0, enable_ff};
      REG_ENTRY_MODE: old_val = {30'h0, mode_ff};
      REG_GAIN:       old_val = {16'h0, gain_ff};
      REG_OFFSET:     old_val = {16'h0, offset_ff};
      REG_CUTOFF:     old_val = {16'h0, cutoff_ff};
      REG_SMOOTH:     old_val = {25'h0, smooth_ff};
      default:        old_val = 32'h00000000;
    endcase
  end

  assign wr_val = merge(old_val, wdata_ff, wstrb_ff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_ff <= ENABLE_RST; // [R4]
    end else if (wr_do && awaddr_ff == REG_CONTROL) begin
      enable_ff <= wr_val[0];
    end
  end

  // only the two documented mode codes are taken; others are dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ff <= AOC_MODE_DIRECT; // [R10]
    end else if (wr_do && awaddr_ff == REG_ENTRY_MODE &&
                 (wr_val[1:0] == AOC_MODE_DIRECT ||
                  wr_val[1:0] == AOC_MODE_LIVE)) begin
      mode_ff <= aoc_mode_t'(wr_val[1:0]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gain_ff <= GAIN_ONE; // [R10]
    end else if (mode_ff == AOC_MODE_LIVE && enter_pulse) begin
      gain_ff <= trial_gain_ff; // [R6]
    end else if (wr_do && awaddr_ff == REG_GAIN &&
                 mode_ff == AOC_MODE_DIRECT) begin
      gain_ff <= wr_val[GAIN_W-1:0]; // [R5]
    end
  end

  // trial starts from the stored gain; steps saturate at both ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trial_gain_ff <= GAIN_ONE;
    end else if (mode_ff != AOC_MODE_LIVE) begin
      trial_gain_ff <= gain_ff;
    end else if (up_pulse && !down_pulse) begin
      trial_gain_ff <= (trial_gain_ff > ~GAIN_STEP) ? '1 :
                       trial_gain_ff + GAIN_STEP; // [R6]
    end else if (down_pulse && !up_pulse) begin
      trial_gain_ff <= (trial_gain_ff < GAIN_STEP) ? '0 :
                       trial_gain_ff - GAIN_STEP; // [R6]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      offset_ff <= OFFSET_RST; // [R10]
    end else if (wr_do && awaddr_ff == REG_OFFSET &&
                 mode_ff == AOC_MODE_DIRECT) begin
      offset_ff <= wr_val[W-1:0]; // [R5]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cutoff_ff <= CUTOFF_RST;
    end else if (wr_do && awaddr_ff == REG_CUTOFF) begin
      cutoff_ff <= wr_val[W-1:0];
    end
  end

  // settings above the top of the range are refused, old value kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smooth_ff <= SMOOTH_RST; // [R10]
    end else if (wr_do && awaddr_ff == REG_SMOOTH &&
                 wr_val[31:PCT_W] == '0 &&
                 wr_val[PCT_W-1:0] <= SMOOTH_MAX) begin
      smooth_ff <= wr_val[PCT_W-1:0]; // [R8]
    end
  end

  // read channel: data registered, one read in flight
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always_comb begin
    nxt_rdata = 32'h00000000;
    case (s_axi_araddr)
      REG_CONTROL:    nxt_rdata = {31'h0, enable_ff};
      REG_ENTRY_MODE: nxt_rdata = {30'h0, mode_ff};
      REG_GAIN:       nxt_rdata = {16'h0, gain_ff};
      REG_OFFSET:     nxt_rdata = {16'h0, offset_ff};
      REG_CUTOFF:     nxt_rdata = {16'h0, cutoff_ff};
      REG_SMOOTH:     nxt_rdata = {25'h0, smooth_ff};
      REG_OUTPUT:     nxt_rdata = {16'h0, y_ff};
      REG_LIVE_GAIN:  nxt_rdata = {16'h0, trial_gain_ff};
      default:        nxt_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // datapath: the only stream that sees the correction is this one [R1]
  assign active_gain = (mode_ff == AOC_MODE_LIVE) ? trial_gain_ff : gain_ff;
  assign prod = $signed(in_value) * $signed({1'b0, active_gain});
  assign sum  = (prod >>> GAIN_FRAC) +
                $signed({{(GAIN_W+1){offset_ff[W-1]}}, offset_ff});

  // saturate rather than wrap: a wrapped flow would read as reversed
  always_comb begin
    corr_val = in_value; // [R3]
    if (enable_ff) begin
      if (sum > $signed({{(GAIN_W+1){1'b0}}, 1'b0, {(W-1){1'b1}}})) begin
        corr_val = {1'b0, {(W-1){1'b1}}};
      end else if (sum < $signed({{(GAIN_W+1){1'b1}}, 1'b1,
                                  {(W-1){1'b0}}})) begin
        corr_val = {1'b1, {(W-1){1'b0}}};
      end else begin
        corr_val = sum[W-1:0]; // [R2]
      end
    end
  end

  // magnitude compare so reverse flow is cut symmetrically
  assign cut_hit = mag(corr_val) < cutoff_ff;
  assign cut_val = cut_hit ? '0 : corr_val; // [R7] [R11]

  assign diff      = $signed({cut_val[W-1], cut_val}) -
                     $signed({y_ff[W-1], y_ff});
  assign step_prod = diff * $signed({1'b0, PCT_FULL - {1'b0, smooth_ff}});
  assign step      = (W+1)'(step_prod / $signed({2'b00, PCT_FULL})); // [R12]
  assign nxt_y_wide = {y_ff[W-1], y_ff} + step;
  assign nxt_y      = nxt_y_wide[W-1:0]; // [R9]

  assign fire = in_valid && in_ready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      y_ff <= '0;
    end else if (fire) begin
      y_ff <= nxt_y; // [R11]
    end
  end

  assign display_value = y_ff; // [R11]

  aoc_pair_buf #(
    .WIDTH (W)
  ) u_out_buf (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (nxt_y),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_value)
  );

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_live_enter;
    mode_ff == AOC_MODE_LIVE && enter_pulse;
  endsequence

  a_reset_defaults: assert property ( // [R4] [R10]
    $rose(aresetn) |-> !enable_ff && gain_ff == GAIN_ONE &&
      offset_ff == OFFSET_RST && mode_ff == AOC_MODE_DIRECT &&
      smooth_ff == SMOOTH_RST)
    else $error("settings not at defaults after reset");

  a_bypass_raw: assert property ( // [R3]
    fire && !enable_ff && smooth_ff == 7'h00 &&
      mag(in_value) >= cutoff_ff |=> y_ff == $past(in_value))
    else $error("raw reading altered while correction off");

  a_corr_unit: assert property ( // [R2]
    fire && enable_ff && mode_ff == AOC_MODE_DIRECT &&
      gain_ff == GAIN_ONE && offset_ff == '0 && smooth_ff == 7'h00 &&
      mag(in_value) >= cutoff_ff |=> display_value == $past(in_value))
    else $error("unit gain zero offset changed the reading");

  a_cutoff_zero: assert property ( // [R7]
    fire && cut_hit && smooth_ff == 7'h00 |=> y_ff == '0 ##0 1)
    else $error("reading below cutoff not forced to zero");

  a_smooth_bound: assert property ( // [R9] [R12]
    fire && smooth_ff != 7'h00 |=>
      mag(W'(y_ff - $past(y_ff))) <= mag($past(diff[W-1:0])) ||
      $past(diff[W]) != $past(diff[W-1]))
    else $error("smoothing overshot the input");

  a_smooth_range: assert property ( // [R8]
    smooth_ff <= SMOOTH_MAX)
    else $error("smoothing setting outside range");

  a_live_store: assert property ( // [R6]
    s_live_enter |=> gain_ff == $past(trial_gain_ff))
    else $error("enter did not store the live gain");

  a_direct_gain: assert property ( // [R5]
    wr_do && awaddr_ff == REG_GAIN && wstrb_ff == 4'hF &&
      mode_ff == AOC_MODE_DIRECT && !enter_pulse |=>
      gain_ff == $past(wdata_ff[GAIN_W-1:0]))
    else $error("direct gain write not stored");

  a_bresp_hold: assert property (
    bvalid_ff && !s_axi_bready |=> bvalid_ff && $stable(bresp_ff))
    else $error("write response dropped before taken");

endmodule

// ==== verilog/aoc_pkg.sv ====
/*
  Shared constants and types of the airflow output conditioner: register
  map, reset values, field widths, fixed-point format and entry modes.
  Assumes a 32-bit AXI4-Lite register bus with 12-bit byte addresses.
*/
package aoc_pkg;

  localparam int DATA_W    = 16;
  localparam int GAIN_W    = 16;
  localparam int GAIN_FRAC = 12;
  localparam int PCT_W     = 7;
  localparam int ADDR_W    = 12;

  // gain is unsigned with GAIN_FRAC fraction bits, 1.000 = 0x1000
  localparam logic [GAIN_W-1:0] GAIN_ONE   = 16'h1000;
  localparam logic [GAIN_W-1:0] GAIN_STEP  = 16'h0008;
  localparam logic [DATA_W-1:0] OFFSET_RST = 16'h0000;
  localparam logic [DATA_W-1:0] CUTOFF_RST = 16'h0000;
  localparam logic [PCT_W-1:0]  SMOOTH_RST = 7'h00;
  localparam logic [PCT_W-1:0]  SMOOTH_MAX = 7'h63;
  localparam logic [7:0]        PCT_FULL   = 8'h64;
  localparam logic              ENABLE_RST = 1'b0;

  localparam logic [ADDR_W-1:0] REG_CONTROL    = 12'h000;
  localparam logic [ADDR_W-1:0] REG_ENTRY_MODE = 12'h004;
  localparam logic [ADDR_W-1:0] REG_GAIN       = 12'h008;
  localparam logic [ADDR_W-1:0] REG_OFFSET     = 12'h00C;
  localparam logic [ADDR_W-1:0] REG_CUTOFF     = 12'h010;
  localparam logic [ADDR_W-1:0] REG_SMOOTH     = 12'h014;
  localparam logic [ADDR_W-1:0] REG_OUTPUT     = 12'h018;
  localparam logic [ADDR_W-1:0] REG_LIVE_GAIN  = 12'h01C;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    AOC_MODE_DIRECT = 2'b01,
    AOC_MODE_LIVE   = 2'b10
  } aoc_mode_t;

  typedef struct packed {
    logic up;
    logic down;
    logic enter;
  } aoc_btn_t;

endpackage

// ==== verilog/aoc_pair_buf.sv ====
/*
  Two-entry buffer with valid/ready on both sides, flop storage.
  Assumes both sides on aclk; in_ready drops only when both entries hold.
*/
`timescale 1ns/10ps
module aoc_pair_buf #(
  parameter int WIDTH = 16
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_ff [2];
  logic             wr_ptr_ff;
  logic             rd_ptr_ff;
  logic [1:0]       count_ff;
  logic             push;
  logic             pop;

  assign in_ready  = (count_ff != 2'h2);
  assign out_valid = (count_ff != 2'h0);
  assign out_data  = mem_ff[rd_ptr_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge aclk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_out_held_stall: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("buffered word changed while stalled");

endmodule

// ==== tb/aoc_host_sink.sv ====
/*
  Host model that takes conditioned results from the output stream.
  Assumes the aclk domain; stall holds ready low to back the stream up.
*/
`timescale 1ns/10ps
module aoc_host_sink
  import aoc_pkg::*;
(
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       stall,
  input  wire logic                       out_valid,
  output logic                            out_ready,
  input  wire logic [aoc_pkg::DATA_W-1:0] out_value,
  output logic                            got,
  output logic      [aoc_pkg::DATA_W-1:0] got_value
);
  // ready is a flop so it only moves just after an edge
  always_ff @(posedge aclk) begin
    if (!aresetn) out_ready <= 1'b0;
    else out_ready <= !stall;
  end
  always_ff @(posedge aclk) begin
    got       <= aresetn && out_valid && out_ready;
    got_value <= out_value;
  end
endmodule

// ==== tb/tb_top.sv ====
/*
  Self-checking bench of the airflow output conditioner.
  Assumes the register map and reset values of aoc_pkg and the host model.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("wrong value at %0t: got %h exp %h", $time, g, e); \
  end \
end
module tb_top;
  import aoc_pkg::*;
  logic             aclk, aresetn, stall;
  logic [11:0]      s_axi_awaddr, s_axi_araddr;
  logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0]      s_axi_wdata, s_axi_rdata;
  logic [3:0]       s_axi_wstrb;
  logic [1:0]       s_axi_bresp, s_axi_rresp, resp;
  logic             s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic             s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic             in_valid, in_ready, out_valid, out_ready, got;
  logic [15:0]      in_value, out_value, display_value, got_value;
  aoc_btn_t         btn;
  logic [15:0]      rx_q[$];
  int               fail_count, compares;

  aoc_conditioner uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .in_valid(in_valid), .in_ready(in_ready),
    .in_value(in_value), .out_valid(out_valid), .out_ready(out_ready),
    .out_value(out_value), .display_value(display_value), .btn(btn));
  aoc_host_sink host (.aclk(aclk), .aresetn(aresetn), .stall(stall),
    .out_valid(out_valid), .out_ready(out_ready), .out_value(out_value),
    .got(got), .got_value(got_value));

  initial aclk = 1'b0;
  always #10 aclk = ~aclk;
  always @(posedge aclk) if (got === 1'b1) rx_q.push_back(got_value);

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    `CHK(s_axi_bvalid, 1'b1)
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    `CHK(s_axi_rvalid, 1'b1)
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    `CHK(d, e)
    `CHK(resp, RESP_OKAY)
  endtask

  task automatic push(input logic [15:0] x);
    @(posedge aclk);
    in_valid <= 1'b1;
    in_value <= x;
    do @(posedge aclk); while (in_ready !== 1'b1);
    in_valid <= 1'b0;
  endtask

  // an empty queue after the wait yields x, which counts as a mismatch
  task automatic pull(input logic [15:0] e);
    int n;
    logic [15:0] v;
    n = 0;
    while (rx_q.size() == 0 && n < 50) begin
      @(posedge aclk);
      n++;
    end
    v = (rx_q.size() > 0) ? rx_q.pop_front() : 16'hXXXX;
    `CHK(v, e)
  endtask

  task automatic smp(input logic [15:0] x, input logic [15:0] e);
    push(x);
    pull(e);
    `CHK(display_value, e)
  endtask

  task automatic press(input aoc_btn_t b);
    @(posedge aclk);
    btn <= b;
    repeat (4) @(posedge aclk);
    btn <= '0;
    repeat (6) @(posedge aclk);
  endtask

  task automatic t_reset;
    logic [11:0] a[7];
    logic [31:0] e[7];
    logic [31:0] d;
    a = '{REG_CONTROL, REG_ENTRY_MODE, REG_GAIN, REG_OFFSET, REG_CUTOFF,
          REG_SMOOTH, REG_LIVE_GAIN};
    e = '{32'h0, 32'h1, {16'h0, GAIN_ONE}, 32'h0, 32'h0, 32'h0,
          {16'h0, GAIN_ONE}};
    `CHK(out_valid, 1'b0)
    `CHK(display_value, 16'h0000)
    for (int i = 0; i < 7; i++) rd_chk(a[i], e[i]);
    rd(12'h020, d);
    `CHK(resp, RESP_SLVERR)
    wr(12'h022, 32'h1);
    `CHK(resp, RESP_SLVERR)
    rd_chk(REG_CONTROL, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_correct;
    wr(REG_GAIN, 32'h2000);
    wr(REG_OFFSET, 32'h5);
    smp(16'd100, 16'd100);
    wr(REG_CONTROL, 32'h1);
    smp(16'd100, 16'd205);
    rd_chk(REG_OUTPUT, 32'd205);
    smp(16'hFF9C, 16'hFF3D);
    wr(REG_OFFSET, 32'h0);
    wr(REG_GAIN, 32'h1000);
    smp(16'h012C, 16'h012C);
    wr(REG_GAIN, 32'h2000);
    $display("test correct done");
  endtask

  // cutoff above the raw reading but equal to the corrected one shows order
  task automatic t_cutoff;
    wr(REG_CUTOFF, 32'h12C);
    smp(16'd149, 16'h0000);
    smp(16'd150, 16'h012C);
    smp(16'hFF6A, 16'hFED4);
    wr(REG_CUTOFF, 32'h0);
    $display("test cutoff done");
  endtask

  task automatic t_smooth;
    wr(REG_CONTROL, 32'h0);
    smp(16'h03E8, 16'h03E8);
    wr(REG_SMOOTH, 32'h32);
    smp(16'h0000, 16'h01F4);
    wr(REG_SMOOTH, 32'h64);
    rd_chk(REG_SMOOTH, 32'h32);
    wr(REG_SMOOTH, 32'h5A);
    smp(16'h0000, 16'h01C2);
    smp(16'h03E8, 16'h01F9);
    wr(REG_SMOOTH, 32'h63);
    rd_chk(REG_SMOOTH, 32'h63);
    wr(REG_SMOOTH, 32'h0);
    smp(16'h0007, 16'h0007);
    $display("test smooth done");
  endtask

  task automatic t_live;
    wr(REG_CONTROL, 32'h1);
    wr(REG_ENTRY_MODE, 32'h2);
    wr(REG_GAIN, 32'h3000);
    rd_chk(REG_GAIN, 32'h2000);
    rd_chk(REG_LIVE_GAIN, 32'h2000);
    press('{up: 1'b1, down: 1'b0, enter: 1'b0});
    rd_chk(REG_LIVE_GAIN, 32'h2008);
    smp(16'h1000, 16'h2008);
    rd_chk(REG_GAIN, 32'h2000);
    press('{up: 1'b0, down: 1'b0, enter: 1'b1});
    rd_chk(REG_GAIN, 32'h2008);
    press('{up: 1'b0, down: 1'b1, enter: 1'b0});
    rd_chk(REG_LIVE_GAIN, 32'h2000);
    wr(REG_ENTRY_MODE, 32'h1);
    rd_chk(REG_ENTRY_MODE, 32'h1);
    $display("test live done");
  endtask

  task automatic t_buffer;
    wr(REG_CONTROL, 32'h0);
    stall <= 1'b1;
    repeat (2) @(posedge aclk);
    push(16'h0011);
    push(16'h0022);
    @(posedge aclk);
    #1;
    `CHK(in_ready, 1'b0)
    `CHK(out_value, 16'h0011)
    stall <= 1'b0;
    push(16'h0033);
    pull(16'h0011);
    pull(16'h0022);
    pull(16'h0033);
    $display("test buffer done");
  endtask

  task automatic print_verdict;
    $display("compares %0d, fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    aresetn = 1'b0;
    stall = 1'b0;
    btn = '0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    {in_valid, in_value} = '0;
    fail_count = 0;
    compares = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_correct();
    t_cutoff();
    t_smooth();
    t_live();
    t_buffer();
    print_verdict();
  end

  // the whole run needs some 250 cycles; the 20000-cycle limit allows some eighty times that
  initial begin
    #400000;
    fail_count++;
    print_verdict();
  end
endmodule
